// ==== drive_health_monitor.v ====
`timescale 1ns/100ps
`default_nettype none
`include "health_monitor_map.vh"
module drive_health_monitor #(
  parameter NUM_ATTR = 4,
  parameter CNT_W = 16,
  parameter [31:0] SEC_CYC = `CLK_HZ,
  parameter [31:0] CAP_ONLINE_CYC = `CAP_ONLINE_MS * (`CLK_HZ / 1000),
  parameter [31:0] CAP_FULL_CYC = `CAP_FULL_MS * (`CLK_HZ / 1000)
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_ATTR-1:0] attr_op,
  input wire [NUM_ATTR-1:0] attr_err,
  input wire host_bus_idle,
  input wire host_bus_reset,
  input wire [7:0] temp_pin,
  input wire [3:0] fault_pin,
  input wire nv_pred_pin,
  input wire seg_done,
  input wire seg_fail,
  output wire nv_pred_save,
  output wire capture_start,
  output wire capture_busy,
  output wire frame_save,
  output wire info_exception,
  output wire st_active,
  output wire [1:0] st_segment,
  output wire st_extended,
  output wire st_seg_start
);
  localparam ST_IDLE = 2'b00;
  localparam ST_ELEC = 2'b01;
  localparam ST_SERVO = 2'b10;
  localparam ST_SCAN = 2'b11;

  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL, `OFS_REFTEMP, `OFS_SENSE, `OFS_STATUS, `OFS_DIAG,
        `OFS_CLEAR, `OFS_INTERVAL, `OFS_THRESH, `OFS_TEMP: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Pins from outside the clock domain pass two flip-flops first.
  // They carry no reset, so they are full when reset ends and the stored flag is real.
  reg [7:0] temp_s1_r, temp_s2_r;
  reg [3:0] fault_s1_r, fault_s2_r;
  reg nvp_s1_r, nvp_s2_r;
  always @(posedge aclk) begin
    if (ce) begin
      temp_s1_r <= temp_pin;
      temp_s2_r <= temp_s1_r;
      fault_s1_r <= fault_pin;
      fault_s2_r <= fault_s1_r;
      nvp_s1_r <= nv_pred_pin;
      nvp_s2_r <= nvp_s1_r;
    end
  end

  // Register file and bus state.
  reg aw_have_r, w_have_r, bvalid_r, rvalid_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r, rdata_r;
  reg [3:0] w_strb_r;
  reg [1:0] bresp_r, rresp_r;
  reg [31:0] ctrl_r, ival_len_r, thresh_r;
  reg [7:0] ref_temp_r;
  reg pred_r, temp_warn_r, round_r, boot_r;
  reg [31:0] rd_val;
  wire [31:0] wr_val;
  wire do_write = ce && aw_have_r && w_have_r && !bvalid_r;
  wire do_read = ce && s_axi_arvalid && !rvalid_r;
  wire wr_ok = is_mapped(aw_addr_r);
  assign wr_val = merge(32'h0, w_data_r, w_strb_r);
  wire monitor_disable = ctrl_r[`CTRL_DISABLE];
  wire online_only_select = ctrl_r[`CTRL_ONLINE];
  wire temp_warning_enable = ctrl_r[`CTRL_TEMPEN];
  wire [3:0] exception_report_method = ctrl_r[`CTRL_EXCEPTION_REPORT_METHOD_HI:`CTRL_EXCEPTION_REPORT_METHOD_LO];
  wire [NUM_ATTR-1:0] attr_pred;
  wire pred_any = |attr_pred;
  wire trip1, trip_any, temp_sample;
  reg [7:0] temp_r;
  wire not_ready = |fault_s2_r;
  reg [1:0] st_state_r;
  reg [3:0] st_result_r;
  reg cap_busy_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bresp_r <= `RESP_OKAY;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0;
      ctrl_r <= 32'h0;
      ref_temp_r <= `TEMP_REF_RST;
      ival_len_r <= {16'h0, `IVAL_RST};
      thresh_r <= {16'h0, `PRED_THR_RST, `ERR_THR_RST};
      pred_r <= 1'b0;
      temp_warn_r <= 1'b0;
      round_r <= 1'b0;
      boot_r <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `RESP_OKAY : `RESP_DECERR;
        case (aw_addr_r)
          `OFS_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
          `OFS_INTERVAL: ival_len_r <= merge(ival_len_r, w_data_r, w_strb_r);
          `OFS_THRESH: thresh_r <= merge(thresh_r, w_data_r, w_strb_r);
          default: ;
        endcase
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_write && aw_addr_r == `OFS_REFTEMP && w_strb_r[0]) begin
        if (w_data_r[7:0] > `TEMP_TRIP1) begin
          ref_temp_r <= `TEMP_TRIP1;
        end else begin
          ref_temp_r <= w_data_r[7:0];
        end
      end
      // Every sticky flag below lets a new event win over a clear in the same cycle.
      if (do_write && aw_addr_r == `OFS_CLEAR && wr_val[`CLEAR_ROUND]) begin
        round_r <= 1'b0;
      end
      if (do_write && aw_addr_r == `OFS_REFTEMP && w_strb_r[0] && w_data_r[7:0] > `TEMP_TRIP1) begin
        round_r <= 1'b1;
      end
      if (do_write && aw_addr_r == `OFS_CLEAR && wr_val[`CLEAR_TEMP]) begin
        temp_warn_r <= 1'b0;
      end
      if (temp_sample && trip_any && temp_warning_enable) begin
        temp_warn_r <= 1'b1;
      end
      // The pending code is reloaded from the non-volatile copy after reset, and the
      // host bus reset does not touch it.
      boot_r <= 1'b0;
      if (do_write && aw_addr_r == `OFS_CLEAR && wr_val[`CLEAR_PRED]) begin
        pred_r <= 1'b0;
      end
      if (boot_r) begin
        pred_r <= nvp_s2_r;
      end else if (pred_any && !monitor_disable) begin
        pred_r <= 1'b1;
      end
      if (do_read) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Sense data, highest priority first.
  reg [23:0] sense_code;
  reg [7:0] sense_fru;
  always @* begin
    sense_fru = 8'h00;
    if (not_ready) begin
      sense_code = fault_s2_r[3] ? `SENSE_NOT_READY_CFG : `SENSE_NOT_READY;
    end else if (pred_r) begin
      sense_code = `SENSE_PRED;
    end else if (temp_warn_r) begin
      sense_code = `SENSE_TEMP;
      sense_fru = temp_r;
    end else if (round_r) begin
      sense_code = `SENSE_ROUND;
    end else begin
      sense_code = `SENSE_NONE;
    end
  end

  always @* begin
    case (s_axi_araddr)
      `OFS_CTRL: rd_val = ctrl_r;
      `OFS_REFTEMP: rd_val = {24'h0, ref_temp_r};
      `OFS_SENSE: rd_val = {sense_code, sense_fru};
      `OFS_STATUS: rd_val = {20'h0, st_result_r, 1'b0, st_active, cap_busy_r, not_ready,
                             round_r, temp_warn_r, pred_r, info_exception};
      `OFS_DIAG: rd_val = {24'h0, st_result_r, 2'b00, st_state_r};
      `OFS_INTERVAL: rd_val = ival_len_r;
      `OFS_THRESH: rd_val = thresh_r;
      `OFS_TEMP: rd_val = {24'h0, temp_r};
      default: rd_val = 32'h0;
    endcase
  end

  assign s_axi_awready = ce && !aw_have_r && !bvalid_r;
  assign s_axi_wready = ce && !w_have_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Attribute monitors; all stop while monitoring is disabled.
  genvar g;
  generate
    for (g = 0; g < NUM_ATTR; g = g + 1) begin : attr
      attr_rate_monitor #(
        .CNT_W(CNT_W),
        .THR_W(8)
      ) u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(!monitor_disable),
        .op(attr_op[g]),
        .err(attr_err[g]),
        .interval_len(ival_len_r[CNT_W-1:0]),
        .err_thresh(thresh_r[7:0]),
        .pred_thresh(thresh_r[15:8]),
        .predict(attr_pred[g]),
        .history()
      );
    end
  endgenerate

  // One-second time base shared by the slow schedules.
  reg [31:0] sec_cnt_r;
  reg sec_tick_r;
  reg [`SEC_W-1:0] cap_sec_r, temp_sec_r, st_sec_r;
  reg cap_due_r, temp_first_r, sample_r, frame_r, cap_start_r;
  reg [31:0] cap_cnt_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_r <= 32'h0;
      sec_tick_r <= 1'b0;
    end else if (ce) begin
      sec_tick_r <= (sec_cnt_r == SEC_CYC - 32'h1);
      sec_cnt_r <= (sec_cnt_r == SEC_CYC - 32'h1) ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  // Capture holds off until the bus is idle and then runs to completion.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_sec_r <= {`SEC_W{1'b0}};
      cap_due_r <= 1'b0;
      cap_busy_r <= 1'b0;
      cap_cnt_r <= 32'h0;
      cap_start_r <= 1'b0;
    end else if (ce) begin
      cap_start_r <= 1'b0;
      if (sec_tick_r && !cap_due_r) begin
        if (cap_sec_r == `CAPTURE_PERIOD_S - 1) begin
          cap_sec_r <= {`SEC_W{1'b0}};
          cap_due_r <= 1'b1;
        end else begin
          cap_sec_r <= cap_sec_r + {{(`SEC_W-1){1'b0}}, 1'b1};
        end
      end
      if (cap_busy_r) begin
        if (cap_cnt_r == 32'h1) begin
          cap_busy_r <= 1'b0;
        end
        cap_cnt_r <= cap_cnt_r - 32'h1;
      end else if (cap_due_r && host_bus_idle && !monitor_disable) begin
        cap_due_r <= 1'b0;
        cap_busy_r <= 1'b1;
        cap_start_r <= 1'b1;
        cap_cnt_r <= online_only_select ? CAP_ONLINE_CYC : CAP_FULL_CYC;
      end else if (cap_due_r && monitor_disable) begin
        cap_due_r <= 1'b0;
      end
    end
  end

  // Thermal sampling at power-up and every ten minutes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      temp_sec_r <= {`SEC_W{1'b0}};
      temp_first_r <= 1'b1;
      sample_r <= 1'b0;
      temp_r <= 8'h00;
      frame_r <= 1'b0;
    end else if (ce) begin
      sample_r <= 1'b0;
      frame_r <= 1'b0;
      // The first sample waits for the synchroniser to fill.
      if (temp_first_r && !boot_r) begin
        temp_first_r <= 1'b0;
        sample_r <= 1'b1;
        temp_r <= temp_s2_r;
      end else if (sec_tick_r) begin
        if (temp_sec_r == `TEMP_PERIOD_S - 1) begin
          temp_sec_r <= {`SEC_W{1'b0}};
          sample_r <= 1'b1;
          temp_r <= temp_s2_r;
        end else begin
          temp_sec_r <= temp_sec_r + {{(`SEC_W-1){1'b0}}, 1'b1};
        end
      end
      if (temp_sample && trip1 && !monitor_disable) begin
        frame_r <= 1'b1;
      end
    end
  end

  assign temp_sample = sample_r;
  assign trip1 = (temp_r > `TEMP_TRIP1);
  assign trip_any = trip1 || (temp_r > ref_temp_r);

  // Self-test sequencer.
  wire [2:0] diag_fc = wr_val[`DIAG_FC_HI:`DIAG_FC_LO];
  wire diag_wr = do_write && aw_addr_r == `OFS_DIAG && w_strb_r[0];
  reg st_ext_r, st_start_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_state_r <= ST_IDLE;
      st_result_r <= `RES_PASS;
      st_ext_r <= 1'b0;
      st_start_r <= 1'b0;
      st_sec_r <= {`SEC_W{1'b0}};
    end else if (ce) begin
      st_start_r <= 1'b0;
      if (sec_tick_r) begin
        st_sec_r <= st_sec_r + {{(`SEC_W-1){1'b0}}, 1'b1};
      end
      case (st_state_r)
        ST_IDLE: begin
          // A drive that is not ready refuses the test; the sense data tells why.
          if (diag_wr && !not_ready && (diag_fc == `FC_SHORT || diag_fc == `FC_EXTENDED)) begin
            st_state_r <= ST_ELEC;
            st_ext_r <= (diag_fc == `FC_EXTENDED);
            st_result_r <= `RES_RUNNING;
            st_start_r <= 1'b1;
            st_sec_r <= {`SEC_W{1'b0}};
          end
        end
        default: begin
          if (host_bus_reset) begin
            st_state_r <= ST_IDLE;
            st_result_r <= `RES_ABORT_RESET;
          end else if (diag_wr && diag_fc == `FC_ABORT) begin
            st_state_r <= ST_IDLE;
            st_result_r <= `RES_ABORT_HOST;
          end else if (seg_done && seg_fail) begin
            // Only errors left after all retries reach seg_fail.
            st_state_r <= ST_IDLE;
            st_result_r <= `RES_FAIL;
          end else if (!st_ext_r && st_sec_r == `SHORT_TEST_S) begin
            st_state_r <= ST_IDLE;
            st_result_r <= `RES_PASS;
          end else if (seg_done) begin
            if (st_state_r == ST_SCAN) begin
              st_state_r <= ST_IDLE;
              st_result_r <= `RES_PASS;
            end else begin
              st_state_r <= st_state_r + 2'b01;
              st_start_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign st_active = (st_state_r != ST_IDLE);
  assign st_segment = st_state_r - 2'b01;
  assign st_extended = st_ext_r;
  assign st_seg_start = st_start_r;
  assign nv_pred_save = pred_r;
  assign capture_start = cap_start_r;
  assign capture_busy = cap_busy_r;
  assign frame_save = frame_r;
  assign info_exception = (exception_report_method != 4'h0) &&
                          (pred_r || temp_warn_r);
endmodule // drive_health_monitor
`default_nettype wire

// ==== health_monitor_map.vh ====
`ifndef HEALTH_MONITOR_MAP_VH
`define HEALTH_MONITOR_MAP_VH

`define CLK_HZ 40000000
`define CAPTURE_PERIOD_S 7200
`define CAP_ONLINE_MS 60
`define CAP_FULL_MS 370
`define TEMP_PERIOD_S 600
`define SHORT_TEST_S 120
`define SEC_W 13

`define OFS_CTRL 8'h00
`define OFS_REFTEMP 8'h04
`define OFS_SENSE 8'h08
`define OFS_STATUS 8'h0C
`define OFS_DIAG 8'h10
`define OFS_CLEAR 8'h14
`define OFS_INTERVAL 8'h18
`define OFS_THRESH 8'h1C
`define OFS_TEMP 8'h20

`define CTRL_DISABLE 0
`define CTRL_ONLINE 1
`define CTRL_TEMPEN 2
`define CTRL_EXCEPTION_REPORT_METHOD_LO 4
`define CTRL_EXCEPTION_REPORT_METHOD_HI 7
`define CLEAR_TEMP 0
`define CLEAR_PRED 1
`define CLEAR_ROUND 2
`define DIAG_FC_LO 5
`define DIAG_FC_HI 7

`define TEMP_TRIP1 8'h44
`define TEMP_REF_RST 8'h44
`define IVAL_RST 16'h03E8
`define ERR_THR_RST 8'h0A
`define PRED_THR_RST 8'h05

`define FC_SHORT 3'h1
`define FC_EXTENDED 3'h2
`define FC_ABORT 3'h4

`define RES_PASS 4'h0
`define RES_ABORT_HOST 4'h1
`define RES_ABORT_RESET 4'h2
`define RES_FAIL 4'h7
`define RES_RUNNING 4'hF

`define SENSE_PRED 24'h015D00
`define SENSE_TEMP 24'h010B01
`define SENSE_ROUND 24'h013700
`define SENSE_NOT_READY 24'h020400
`define SENSE_NOT_READY_CFG 24'h020403
`define SENSE_NONE 24'h000000

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== attr_rate_monitor.v ====
`timescale 1ns/100ps
`default_nettype none
module attr_rate_monitor #(
  parameter CNT_W = 16,
  parameter THR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire enable,
  input wire op,
  input wire err,
  input wire [CNT_W-1:0] interval_len,
  input wire [THR_W-1:0] err_thresh,
  input wire [THR_W-1:0] pred_thresh,
  output wire predict,
  output wire [THR_W-1:0] history
);
  reg [CNT_W-1:0] ival_r;
  reg [THR_W-1:0] fail_r;
  reg [THR_W-1:0] hist_r;
  wire [CNT_W-1:0] ival_nxt = ival_r + {{(CNT_W-1){1'b0}}, op};
  wire [THR_W-1:0] fail_nxt = fail_r + {{(THR_W-1){1'b0}}, err};
  wire bad = (fail_nxt > err_thresh);
  wire good = !bad && (ival_nxt >= interval_len);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ival_r <= {CNT_W{1'b0}};
      fail_r <= {THR_W{1'b0}};
      hist_r <= {THR_W{1'b0}};
    end else if (ce && enable) begin
      if (bad || good) begin
        ival_r <= {CNT_W{1'b0}};
        fail_r <= {THR_W{1'b0}};
      end else begin
        ival_r <= ival_nxt;
        fail_r <= fail_nxt;
      end
      if (bad && hist_r != {THR_W{1'b1}}) begin
        hist_r <= hist_r + {{(THR_W-1){1'b0}}, 1'b1};
      end else if (good && hist_r != {THR_W{1'b0}}) begin
        hist_r <= hist_r - {{(THR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // A zero threshold would flag a healthy drive, so it never predicts.
  assign predict = (pred_thresh != {THR_W{1'b0}}) && (hist_r >= pred_thresh);
  assign history = hist_r;
endmodule // attr_rate_monitor
`default_nettype wire

// ==== drive_mech_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module drive_mech_model (
  input wire aclk,
  input wire st_seg_start,
  input wire [1:0] st_segment,
  input wire [7:0] dly,
  input wire [2:0] bad_seg,
  output logic seg_done,
  output logic seg_fail
);
  logic run = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [1:0] seg = 2'h0;
  initial begin
    seg_done = 1'b0;
    seg_fail = 1'b0;
  end
  // Recovered errors never reach seg_fail; only the commanded segment fails.
  always @(posedge aclk) begin
    seg_done <= 1'b0;
    seg_fail <= 1'b0;
    if (st_seg_start) begin
      run <= 1'b1;
      cnt <= dly;
      seg <= st_segment;
    end else if (run && cnt == 8'h00 && bad_seg != 3'h7) begin
      run <= 1'b0;
      seg_done <= 1'b1;
      seg_fail <= ({1'b0, seg} + 3'h1 == bad_seg);
    end else if (run && cnt != 8'h00) begin
      // A bad_seg of 7 stalls the segment, so a short test must end on its timer.
      cnt <= cnt - 8'h01;
    end
  end
endmodule // drive_mech_model
`default_nettype wire

// ==== drive_health_monitor_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module health_checker (
  input wire aclk,
  input wire aresetn,
  input wire host_bus_idle,
  input wire host_bus_reset,
  input wire seg_done,
  input wire seg_fail,
  input wire capture_start,
  input wire capture_busy,
  input wire frame_save,
  input wire st_active,
  input wire [1:0] st_segment,
  input wire st_seg_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cap_idle_a: assert property (capture_start |-> $past(host_bus_idle))
    else $error("capture began on a busy host bus");
  busy_min_a: assert property (capture_start |=> capture_busy [*6])
    else $error("capture busy too short");
  no_restart_a: assert property (capture_busy && $past(capture_busy) |-> !capture_start)
    else $error("capture restarted while busy");
  frame_once_a: assert property (frame_save |=> !frame_save)
    else $error("more than one frame saved");
  seg_order_a: assert property (st_active && $past(st_active) && st_segment != $past(st_segment)
    |-> st_segment == $past(st_segment) + 2'h1)
    else $error("segment order broken");
  seg_live_a: assert property (st_seg_start |-> st_active)
    else $error("segment start outside a test");
  fail_stop_a: assert property (st_active && seg_done && seg_fail |-> ##[1:2] !st_active)
    else $error("failed test kept running");
  go_on_a: assert property (st_active && seg_done && !seg_fail && !host_bus_reset
    && st_segment != 2'h2 |=> st_active)
    else $error("test stopped on a good segment");
  reset_stop_a: assert property (st_active && host_bus_reset |-> ##[1:2] !st_active)
    else $error("bus reset did not stop the test");
endmodule // health_checker
bind drive_health_monitor health_checker i_health_checker (.aclk(aclk), .aresetn(aresetn),
  .host_bus_idle(host_bus_idle), .host_bus_reset(host_bus_reset), .seg_done(seg_done),
  .seg_fail(seg_fail), .capture_start(capture_start), .capture_busy(capture_busy),
  .frame_save(frame_save), .st_active(st_active), .st_segment(st_segment),
  .st_seg_start(st_seg_start));
`default_nettype wire

// ==== drive_health_monitor_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "health_monitor_map.vh"
module drive_health_monitor_bench;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, hreset = 0, idle = 1, nvp = 0, cst, cbusy;
  logic [7:0] awaddr = 0, araddr = 0, temp = 8'd25, dly = 8'd10;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] op = 0, er = 0, fault = 0;
  logic [2:0] bad_seg = 0;
  logic [1:0] bresp, rresp, r, st_seg;
  logic awready, wready, bvalid, arready, rvalid, pred_save, frame, ie, act, ext, sst, sd, sf;
  int num_errors = 0, tests_run = 0, frames = 0, segs = 0, k, s0, caps = 0, cyc = 0;
  localparam logic [31:0] CAP_FULL = 32'd37;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (frame) frames++;
    if (sst) segs++;
    if (cst) caps++;
    if (aresetn) cyc++;
    if (pred_save) nvp <= 1'b1;
  end
  drive_health_monitor #(.SEC_CYC(32'd10), .CAP_FULL_CYC(CAP_FULL))
    i_drive_health_monitor (.aclk(aclk),
    .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .attr_op(op), .attr_err(er), .host_bus_idle(idle), .host_bus_reset(hreset),
    .temp_pin(temp), .fault_pin(fault), .nv_pred_pin(nvp), .seg_done(sd), .seg_fail(sf),
    .nv_pred_save(pred_save), .capture_start(cst), .capture_busy(cbusy), .frame_save(frame),
    .info_exception(ie), .st_active(act), .st_segment(st_seg), .st_extended(ext),
    .st_seg_start(sst));
  drive_mech_model i_drive_mech_model (.aclk(aclk), .st_seg_start(sst), .st_segment(st_seg),
    .dly(dly), .bad_seg(bad_seg), .seg_done(sd), .seg_fail(sf));
  task conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task fail_out();
    num_errors++;
    $display("[ERR] %0t wait limit reached", $time);
    conclude();
  endtask
  task chk(input [31:0] s, input [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) fail_out();
  endtask
  task rd(input [7:0] a, output [31:0] q, output [1:0] p);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    q = rdata;
    p = rresp;
    rready <= 1'b0;
    if (n == 50) fail_out();
  endtask
  task wait_temp(input [7:0] t);
    for (k = 0; k < 400; k++) begin
      repeat (50) @(posedge aclk);
      rd(`OFS_TEMP, d, r);
      if (d[7:0] === t) break;
    end
    if (k == 400) fail_out();
  endtask
  task wait_idle();
    for (k = 0; k < 3000 && act !== 1'b0; k++) @(posedge aclk);
    if (k == 3000) fail_out();
  endtask
  task t_regs();
    rd(`OFS_TEMP, d, r);
    chk(d[7:0], 8'd25);
    rd(`OFS_REFTEMP, d, r);
    chk(d[7:0], `TEMP_REF_RST);
    wr(`OFS_REFTEMP, 32'h00000045);
    rd(`OFS_REFTEMP, d, r);
    chk(d[7:0], 8'h44);
    rd(`OFS_SENSE, d, r);
    chk(d[31:8], `SENSE_ROUND);
    wr(`OFS_REFTEMP, 32'h00000030);
    rd(`OFS_REFTEMP, d, r);
    chk(d[7:0], 8'h30);
    wr(`OFS_CLEAR, 32'h00000004);
    rd(8'hFC, d, r);
    chk(r, `RESP_DECERR);
    $display("t_regs done");
  endtask
  // A reading of 68 trips only the user point; the fixed point needs strictly more.
  task t_temp();
    wr(`OFS_CTRL, 32'h00000014);
    temp <= 8'd68;
    wait_temp(8'd68);
    chk(k > 90, 1);
    rd(`OFS_SENSE, d, r);
    chk(d, {`SENSE_TEMP, 8'd68});
    chk(frames, 0);
    chk(ie, 1'b1);
    wr(`OFS_CLEAR, 32'h00000001);
    temp <= 8'd69;
    wait_temp(8'd69);
    repeat (4) @(posedge aclk);
    chk(frames, 1);
    rd(`OFS_STATUS, d, r);
    chk(d[2], 1'b1);
    $display("t_temp done");
  endtask
  task iv(input int ops, input int errs);
    for (int i = 0; i < ops; i++) begin
      @(posedge aclk);
      op <= 4'h1;
      er <= {3'h0, i < errs};
      @(posedge aclk);
      op <= 4'h0;
      er <= 4'h0;
    end
  endtask
  task t_attr();
    wr(`OFS_CTRL, 32'h00000010);
    wr(`OFS_INTERVAL, 32'h00000004);
    wr(`OFS_THRESH, 32'h00000201);
    iv(2, 2);
    iv(4, 1);
    iv(2, 2);
    rd(`OFS_STATUS, d, r);
    chk(d[1], 1'b0);
    iv(2, 2);
    repeat (3) @(posedge aclk);
    rd(`OFS_STATUS, d, r);
    chk(d[1], 1'b1);
    rd(`OFS_SENSE, d, r);
    chk(d[31:8], `SENSE_PRED);
    chk(pred_save, 1'b1);
    $display("t_attr done");
  endtask
  task st_run(input [31:0] fc, input [3:0] res);
    wr(`OFS_DIAG, fc);
    wait_idle();
    rd(`OFS_DIAG, d, r);
    chk(d[7:4], res);
  endtask
  task t_st();
    s0 = segs;
    wr(`OFS_DIAG, 32'h00000020);
    repeat (3) @(posedge aclk);
    chk({act, ext}, 2'h2);
    st_run(32'h00000000, `RES_PASS);
    chk(k < 1200, 1);
    chk(segs - s0, 3);
    bad_seg <= 3'h2;
    st_run(32'h00000040, `RES_FAIL);
    bad_seg <= 3'h0;
    dly <= 8'd200;
    wr(`OFS_DIAG, 32'h00000040);
    st_run(32'h00000080, `RES_ABORT_HOST);
    wr(`OFS_DIAG, 32'h00000040);
    hreset <= 1'b1;
    @(posedge aclk);
    hreset <= 1'b0;
    st_run(32'h00000000, `RES_ABORT_RESET);
    bad_seg <= 3'h7;
    st_run(32'h00000020, `RES_PASS);
    chk(k > 1150 && k < 1250, 1);
    bad_seg <= 3'h0;
    rd(`OFS_STATUS, d, r);
    chk(d[1], 1'b1);
    fault <= 4'h8;
    repeat (5) @(posedge aclk);
    rd(`OFS_SENSE, d, r);
    chk(d[31:8], `SENSE_NOT_READY_CFG);
    wr(`OFS_DIAG, 32'h00000020);
    repeat (3) @(posedge aclk);
    chk(act, 1'b0);
    fault <= 4'h1;
    repeat (5) @(posedge aclk);
    rd(`OFS_SENSE, d, r);
    chk(d[31:8], `SENSE_NOT_READY);
    $display("t_st done");
  endtask
  // Capture falls due after 7200 ticks; the bus is kept busy past that point first.
  task t_cap();
    int n, busy;
    busy = 0;
    idle <= 1'b0;
    for (n = 0; n < 80000 && cyc < 73000; n++) @(posedge aclk);
    if (cyc < 73000) fail_out();
    chk(caps, 0);
    idle <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (cbusy) busy++;
    end
    chk(caps, 1);
    chk(busy, CAP_FULL);
    $display("t_cap done");
  endtask
  // A second reset stands for a power cycle; the stored flag must come back.
  task t_nv();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`OFS_STATUS, d, r);
    chk(d[1], 1'b1);
    chk(pred_save, 1'b1);
    $display("t_nv done");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_regs();
    t_temp();
    t_attr();
    t_st();
    t_cap();
    t_nv();
    conclude();
  end
endmodule // drive_health_monitor_bench
`default_nettype wire
